// ===== aspc_pkg.sv
// package: offsets, resets, timing constants and types for the alarm and sample period block
package aspc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte address of the low byte)
  localparam logic [6:0] OFS_ALM2_LEVEL = 7'h22;
  localparam logic [6:0] OFS_ALM2_COUNT = 7'h26;
  localparam logic [6:0] OFS_ALARM_CONTROL = 7'h28;
  localparam logic [6:0] OFS_SMPL_PER = 7'h36;
  localparam logic [6:0] OFS_COMMAND = 7'h3E;

  // values after power-up
  localparam logic [15:0] RST_ALM2_LEVEL = 16'h0000;
  localparam logic [15:0] RST_ALM2_COUNT = 16'h0000;
  localparam logic [15:0] RST_ALARM_CONTROL = 16'h0000;
  localparam logic [15:0] RST_SMPL_PER = 16'h000A;

  // field positions and masks
  localparam int LEVEL_GT_BIT = 15;
  localparam int PER_TB_BIT = 7;
  localparam int CMD_FLASH_BIT = 3;
  localparam logic [15:0] MASK_LEVEL = 16'hBFFF;
  localparam logic [15:0] MASK_COUNT = 16'h00FF;
  localparam logic [15:0] MASK_CTRL = 16'hFF07;
  localparam logic [15:0] MASK_PER = 16'h00FF;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ = 250;
  localparam int TB_SHORT_NS = 122_100;
  localparam int TB_LONG_NS = 3_784_000;
  localparam int TB_SHORT_CYC = TB_SHORT_NS * CLK_MHZ / 1000;
  localparam int TB_LONG_CYC = TB_LONG_NS * CLK_MHZ / 1000;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    SRC_OFF, SRC_SUPPLY, SRC_XACC, SRC_YACC, SRC_AUX, SRC_TEMP, SRC_XINC, SRC_YINC
  } aspc_src_t;

  typedef struct packed {
    logic roc2;
    aspc_src_t src2;
    logic roc1;
    aspc_src_t src1;
    logic [4:0] unused;
    logic out_en;
    logic pol;
    logic line_sel;
  } aspc_alarm_control_t;

  typedef struct packed {
    logic rate_of_change_mode;
    aspc_src_t src;
    logic [15:0] level;
    logic [7:0] count;
  } aspc_alm_cfg_t;

  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } aspc_spi_frame_t;

  typedef logic [6:0][13:0] aspc_samples_t;

endpackage

// ===== aspc_alarm_eval.sv
// one alarm: threshold or rate-of-change comparison on a selected output
module aspc_alarm_eval
  import aspc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // setup and data
  input aspc_pkg::aspc_alm_cfg_t cfg_in,
  input aspc_pkg::aspc_samples_t samples_in,
  input wire logic tick_in,
  // result
  output logic active_out
);
  import aspc_pkg::*;

  function automatic logic src_signed(input aspc_src_t s);
    return (s == SRC_XACC) || (s == SRC_YACC) || (s == SRC_XINC) || (s == SRC_YINC);
  endfunction

  function automatic logic signed [15:0] widen(input logic [13:0] v, input logic sgn);
    return sgn ? {{2{v[13]}}, v} : {2'b00, v};
  endfunction

  logic [13:0] raw;
  logic signed [15:0] val, lvl, prev_r;
  logic signed [24:0] sum_r, sum_nxt, limit;
  logic [7:0] n_r, cnt_eff;
  logic primed_r, roc_hit_r, gt;

  always_comb begin
    raw = (cfg_in.src == SRC_OFF) ? 14'h0000 : samples_in[cfg_in.src - 3'h1];
    val = widen(raw, src_signed(cfg_in.src));
    lvl = widen(cfg_in.level[13:0], src_signed(cfg_in.src));
    gt = cfg_in.level[LEVEL_GT_BIT];
    cnt_eff = (cfg_in.count == 8'h00) ? 8'h01 : cfg_in.count;
    sum_nxt = sum_r + 25'(val - prev_r);
    limit = lvl * $signed({1'b0, cnt_eff});
  end

  // average over n samples compared as sum against level times n
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !cfg_in.rate_of_change_mode || cfg_in.src == SRC_OFF) begin
      prev_r <= 16'sh0000;
      sum_r <= 25'sh0;
      n_r <= 8'h00;
      primed_r <= 1'b0;
      roc_hit_r <= 1'b0;
    end else if (tick_in) begin
      prev_r <= val;
      primed_r <= 1'b1;
      if (primed_r) begin
        if (n_r + 8'h01 >= cnt_eff) begin
          roc_hit_r <= gt ? (sum_nxt > limit) : (sum_nxt < limit);
          sum_r <= 25'sh0;
          n_r <= 8'h00;
        end else begin
          sum_r <= sum_nxt;
          n_r <= n_r + 8'h01;
        end
      end
    end
  end

  // threshold uses the live value, never a filtered one
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cfg_in.src == SRC_OFF) begin
      active_out <= 1'b0;
    end else if (cfg_in.rate_of_change_mode) begin
      active_out <= roc_hit_r;
    end else begin
      active_out <= gt ? (val > lvl) : (val < lvl);
    end
  end

endmodule

// ===== aspc_top.sv
// top: spi register access, alarm control, alarm pin and sample period timer
//////////////////////////////////////////////////////////////////////////////
// How it works
// - alarm two level bit 15: 1 active above level, 0 active below.
// - level is 14 low bits, bit 14 unused, format follows monitored output.
// - rate mode averages change over sample count and compares with the level.
// - alarm two sample count is kept across RESET_N_IN, cleared at power-on.
// - control bit 15 and bit 11 pick rate mode for alarm two and one.
// - source fields 14:12 and 10:8; zero disables that alarm.
// - source codes 1..7: supply, x accel, y accel, aux, temp, x incl, y incl.
// - control bit 2 enables alarm pin; bit 1 sets its active level.
// - control bit 0 picks second digital line when set, first otherwise.
// - all seven outputs update together at the one sample period rate.
// - the period covers sampling, processing and updating all seven outputs.
// - period bit 7 picks 122.1 us or 3.784 ms time base.
// - period bits 6:0 give count; period is base times count plus one.
// - power-up period value is ten on short base, about 1343 us.
// - period survives reset only after the flash update command bit 3.
// - printed defaults hold only until the first register write.
// - alarm pin asserts when either alarm is active, not saying which.
// - comparisons use instantaneous values, not filtered ones.
// - alarm pin never latches; it tracks the live condition.
module aspc_top
  import aspc_pkg::*;
#(
  parameter int SHORT_CYC = TB_SHORT_CYC,
  parameter int LONG_CYC = TB_LONG_CYC
) (
  // clock and resets
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic POWER_ON_N_IN,
  // serial port
  input wire logic SPI_CS_N_IN,
  input wire logic SPI_SCLK_IN,
  input wire logic SPI_MOSI_IN,
  output logic SPI_MISO_OUT,
  output logic SPI_MISO_OE_N_OUT,
  // measured data and alarm one setup
  input aspc_pkg::aspc_samples_t SAMPLES_IN,
  input wire logic [15:0] ALARM_ONE_LEVEL_IN,
  input wire logic [7:0] ALARM_ONE_COUNT_IN,
  // status
  output logic GROUP_UPDATE_OUT,
  output logic ALARM_ONE_ACTIVE_OUT,
  output logic ALARM_TWO_ACTIVE_OUT,
  // digital lines
  input wire logic DIGITAL_LINE_FIRST_IN,
  output logic DIGITAL_LINE_FIRST_OUT,
  output logic DIGITAL_LINE_FIRST_OE_N_OUT,
  input wire logic DIGITAL_LINE_SECOND_IN,
  output logic DIGITAL_LINE_SECOND_OUT,
  output logic DIGITAL_LINE_SECOND_OE_N_OUT
);
  import aspc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic [2:0] sync1_r, sync2_r, prev_r;
  logic cs_n, sclk_rise, sclk_fall, cs_fall;
  logic [15:0] rx_shift_r;
  logic [15:0] tx_shift_r;
  logic [4:0] bit_cnt_r;
  logic frame_done;
  aspc_spi_frame_t frame;
  logic [15:0] rd_word_r;
  logic [6:0] rd_addr;

  logic [15:0] alm2_level_r;
  logic [15:0] alm2_count_r;
  aspc_alarm_control_t alarm_control_r;
  logic [15:0] smpl_per_r;

  logic [15:0] nv_level_r;
  logic [15:0] nv_count_r;
  logic [15:0] nv_per_r;
  logic flash_cmd;

  logic [19:0] base_cnt_r;
  logic [6:0] per_cnt_r;
  logic cur_tb_r;
  logic [6:0] cur_ns_r;
  logic [19:0] base_last;
  logic base_wrap;

  aspc_alm_cfg_t cfg1, cfg2;
  logic alarm1, alarm2, any_alarm, pin_level;

  //////////////////////////////////////////////////////////////////////////
  // helper functions

  // byte merge into a 16-bit register, unused bits forced low
  function automatic logic [15:0] merge_byte(
    input logic [15:0] old,
    input logic hi,
    input logic [7:0] data,
    input logic [15:0] mask
  );
    logic [15:0] v;
    v = hi ? {data, old[7:0]} : {old[15:8], data};
    return v & mask;
  endfunction

  // address decode shared by write and read paths
  function automatic logic hits(input logic [6:0] a, input logic [6:0] ofs);
    return {a[6:1], 1'b0} == ofs;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: cs, sclk, mosi

  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
          sync1_r[i] <= 1'b1;
          sync2_r[i] <= 1'b1;
          prev_r[i] <= 1'b1;
        end else begin
          sync1_r[i] <= (i == 0) ? SPI_CS_N_IN : (i == 1) ? SPI_SCLK_IN : SPI_MOSI_IN;
          sync2_r[i] <= sync1_r[i];
          prev_r[i] <= sync2_r[i];
        end
      end
    end
  endgenerate

  assign cs_n = sync2_r[0];
  assign cs_fall = prev_r[0] && !sync2_r[0];
  // sclk idles high; data in on rise, data out on fall
  assign sclk_rise = !cs_n && !prev_r[1] && sync2_r[1];
  assign sclk_fall = !cs_n && prev_r[1] && !sync2_r[1];

  //////////////////////////////////////////////////////////////////////////
  // serial receive

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN || cs_n) begin
      bit_cnt_r <= 5'h00;
      rx_shift_r <= 16'h0000;
    end else if (sclk_rise) begin
      rx_shift_r <= {rx_shift_r[14:0], sync2_r[2]};
      bit_cnt_r <= (bit_cnt_r == SPI_FRAME_BITS - 5'h01) ? 5'h00 : bit_cnt_r + 5'h01;
    end
  end

  // last bit of a frame closes it; a short frame is dropped at cs rise
  assign frame_done = sclk_rise && (bit_cnt_r == SPI_FRAME_BITS - 5'h01);
  assign frame = {rx_shift_r[14:0], sync2_r[2]};
  assign flash_cmd = frame_done && frame.wr && frame.addr == OFS_COMMAND
    && frame.data[CMD_FLASH_BIT];
  assign rd_addr = frame.addr;

  //////////////////////////////////////////////////////////////////////////
  // serial transmit: read answer goes out in the next frame

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      rd_word_r <= 16'h0000;
    end else if (frame_done && !frame.wr) begin
      if (hits(rd_addr, OFS_ALM2_LEVEL)) begin
        rd_word_r <= alm2_level_r;
      end else if (hits(rd_addr, OFS_ALM2_COUNT)) begin
        rd_word_r <= alm2_count_r;
      end else if (hits(rd_addr, OFS_ALARM_CONTROL)) begin
        rd_word_r <= alarm_control_r;
      end else if (hits(rd_addr, OFS_SMPL_PER)) begin
        rd_word_r <= smpl_per_r;
      end else begin
        rd_word_r <= 16'h0000;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      tx_shift_r <= 16'h0000;
      SPI_MISO_OUT <= 1'b0;
    end else if (cs_fall) begin
      tx_shift_r <= rd_word_r;
    end else if (sclk_fall) begin
      SPI_MISO_OUT <= tx_shift_r[15];
      tx_shift_r <= {tx_shift_r[14:0], 1'b0};
    end
  end

  // released while cs is high so other devices can share the line
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      SPI_MISO_OE_N_OUT <= 1'b1;
    end else begin
      SPI_MISO_OE_N_OUT <= cs_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // nonvolatile store: survives RESET_N_IN, cleared only at power-on

  always_ff @(posedge CORE_CLK_IN) begin
    if (!POWER_ON_N_IN) begin
      nv_level_r <= RST_ALM2_LEVEL;
      nv_count_r <= RST_ALM2_COUNT;
      nv_per_r <= RST_SMPL_PER;
    end else begin
      if (frame_done && frame.wr && hits(frame.addr, OFS_ALM2_LEVEL)) begin
        nv_level_r <= merge_byte(nv_level_r, frame.addr[0], frame.data, MASK_LEVEL);
      end
      if (frame_done && frame.wr && hits(frame.addr, OFS_ALM2_COUNT)) begin
        nv_count_r <= merge_byte(nv_count_r, frame.addr[0], frame.data, MASK_COUNT);
      end
      if (flash_cmd) begin
        nv_per_r <= smpl_per_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // working registers

  always_ff @(posedge CORE_CLK_IN) begin
    if (!POWER_ON_N_IN) begin
      alm2_level_r <= RST_ALM2_LEVEL;
      alm2_count_r <= RST_ALM2_COUNT;
    end else if (!RESET_N_IN) begin
      alm2_level_r <= nv_level_r;
      alm2_count_r <= nv_count_r;
    end else if (frame_done && frame.wr) begin
      if (hits(frame.addr, OFS_ALM2_LEVEL)) begin
        alm2_level_r <= merge_byte(alm2_level_r, frame.addr[0], frame.data, MASK_LEVEL);
      end
      if (hits(frame.addr, OFS_ALM2_COUNT)) begin
        alm2_count_r <= merge_byte(alm2_count_r, frame.addr[0], frame.data, MASK_COUNT);
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!POWER_ON_N_IN || !RESET_N_IN) begin
      alarm_control_r <= RST_ALARM_CONTROL;
    end else if (frame_done && frame.wr && hits(frame.addr, OFS_ALARM_CONTROL)) begin
      alarm_control_r <= merge_byte(alarm_control_r, frame.addr[0], frame.data, MASK_CTRL);
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!POWER_ON_N_IN) begin
      smpl_per_r <= RST_SMPL_PER;
    end else if (!RESET_N_IN) begin
      smpl_per_r <= nv_per_r;
    end else if (frame_done && frame.wr && hits(frame.addr, OFS_SMPL_PER)) begin
      smpl_per_r <= merge_byte(smpl_per_r, frame.addr[0], frame.data, MASK_PER);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sample period timer

  // a period is the whole group cycle, not a per-channel slot
  assign base_last = cur_tb_r ? 20'(LONG_CYC - 1) : 20'(SHORT_CYC - 1);
  assign base_wrap = (base_cnt_r == base_last);

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN || !POWER_ON_N_IN) begin
      base_cnt_r <= 20'h0_0000;
      per_cnt_r <= 7'h00;
      cur_tb_r <= RST_SMPL_PER[PER_TB_BIT];
      cur_ns_r <= RST_SMPL_PER[6:0];
      GROUP_UPDATE_OUT <= 1'b0;
    end else begin
      GROUP_UPDATE_OUT <= 1'b0;
      if (!base_wrap) begin
        base_cnt_r <= base_cnt_r + 20'h0_0001;
      end else begin
        base_cnt_r <= 20'h0_0000;
        if (per_cnt_r != cur_ns_r) begin
          per_cnt_r <= per_cnt_r + 7'h01;
        end else begin
          per_cnt_r <= 7'h00;
          GROUP_UPDATE_OUT <= 1'b1;
          cur_tb_r <= smpl_per_r[PER_TB_BIT];
          cur_ns_r <= smpl_per_r[6:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // alarm evaluation

  always_comb begin
    cfg1.rate_of_change_mode = alarm_control_r.roc1;
    cfg1.src = alarm_control_r.src1;
    cfg1.level = ALARM_ONE_LEVEL_IN;
    cfg1.count = ALARM_ONE_COUNT_IN;
    cfg2.rate_of_change_mode = alarm_control_r.roc2;
    cfg2.src = alarm_control_r.src2;
    cfg2.level = alm2_level_r;
    cfg2.count = alm2_count_r[7:0];
  end

  aspc_alarm_eval u_alarm_one (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .cfg_in(cfg1),
    .samples_in(SAMPLES_IN),
    .tick_in(GROUP_UPDATE_OUT),
    .active_out(alarm1)
  );

  aspc_alarm_eval u_alarm_two (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .cfg_in(cfg2),
    .samples_in(SAMPLES_IN),
    .tick_in(GROUP_UPDATE_OUT),
    .active_out(alarm2)
  );

  assign ALARM_ONE_ACTIVE_OUT = alarm1;
  assign ALARM_TWO_ACTIVE_OUT = alarm2;

  //////////////////////////////////////////////////////////////////////////
  // alarm pin on a digital line

  // shared pin: cannot tell which alarm fired, software must poll
  assign any_alarm = alarm1 || alarm2;
  assign pin_level = alarm_control_r.pol ? any_alarm : !any_alarm;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      DIGITAL_LINE_FIRST_OUT <= 1'b0;
      DIGITAL_LINE_FIRST_OE_N_OUT <= 1'b1;
      DIGITAL_LINE_SECOND_OUT <= 1'b0;
      DIGITAL_LINE_SECOND_OE_N_OUT <= 1'b1;
    end else begin
      // follows the live condition every cycle, no latch
      DIGITAL_LINE_FIRST_OUT <= pin_level;
      DIGITAL_LINE_SECOND_OUT <= pin_level;
      DIGITAL_LINE_FIRST_OE_N_OUT <= !(alarm_control_r.out_en && !alarm_control_r.line_sel);
      DIGITAL_LINE_SECOND_OE_N_OUT <= !(alarm_control_r.out_en && alarm_control_r.line_sel);
    end
  end

endmodule

// ===== aspc_top_sva.sv
// checker: timer and alarm pin relations seen at the top ports
module aspc_top_sva #(
  parameter int SHORT_CYC = 8,
  parameter int LONG_CYC = 20
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  // serial port
  input wire logic SPI_CS_N_IN,
  input wire logic SPI_MISO_OE_N_OUT,
  // status
  input wire logic GROUP_UPDATE_OUT,
  input wire logic ALARM_ONE_ACTIVE_OUT,
  input wire logic ALARM_TWO_ACTIVE_OUT,
  // digital lines
  input wire logic DIGITAL_LINE_FIRST_OUT,
  input wire logic DIGITAL_LINE_FIRST_OE_N_OUT,
  input wire logic DIGITAL_LINE_SECOND_OUT,
  input wire logic DIGITAL_LINE_SECOND_OE_N_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap_r;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  ////////////////////////////////////////////////////////////////////////////
  // cycles since the last group update; a counter keeps the bound out of repetitions
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN || GROUP_UPDATE_OUT)
      gap_r <= 0;
    else
      gap_r <= gap_r + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_upd_pulse: assert property (p_upd_pulse)
    else $error("group update held longer than one cycle");
  property p_upd_pulse;
    GROUP_UPDATE_OUT |=> !GROUP_UPDATE_OUT;
  endproperty
  a_upd_min: assert property (p_upd_min)
    else $error("group updates closer than one short time base");
  property p_upd_min;
    GROUP_UPDATE_OUT |-> gap_r >= SHORT_CYC - 1;
  endproperty
  a_upd_max: assert property (p_upd_max)
    else $error("group update missing for longer than the longest period");
  property p_upd_max;
    gap_r < LONG_CYC * 128;
  endproperty
  a_line_excl: assert property (p_line_excl)
    else $error("both digital lines driven at once");
  property p_line_excl;
    DIGITAL_LINE_FIRST_OE_N_OUT || DIGITAL_LINE_SECOND_OE_N_OUT;
  endproperty
  a_line_same: assert property (p_line_same)
    else $error("digital lines carry different alarm levels");
  property p_line_same;
    DIGITAL_LINE_FIRST_OUT == DIGITAL_LINE_SECOND_OUT;
  endproperty
  a_pin_track: assert property (p_pin_track)
    else $error("alarm pin did not follow the alarm condition");
  property p_pin_track;
    !DIGITAL_LINE_FIRST_OE_N_OUT && $past(!DIGITAL_LINE_FIRST_OE_N_OUT)
      && $changed(ALARM_ONE_ACTIVE_OUT || ALARM_TWO_ACTIVE_OUT)
      |=> $changed(DIGITAL_LINE_FIRST_OUT);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not at reset values after reset");
  property p_reset_quiet;
    $rose(RESET_N_IN) |-> !GROUP_UPDATE_OUT && !ALARM_ONE_ACTIVE_OUT
      && !ALARM_TWO_ACTIVE_OUT && DIGITAL_LINE_FIRST_OE_N_OUT && DIGITAL_LINE_SECOND_OE_N_OUT;
  endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("serial output driven while deselected");
  property p_miso_idle;
    SPI_CS_N_IN [*5] |-> SPI_MISO_OE_N_OUT;
  endproperty
endmodule

// ===== aspc_host_model.sv
// partner: spi host that frames register accesses, mode 3
module aspc_host_model
  import aspc_pkg::*;
(
  // clock
  input wire logic clk_in,
  // serial port
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out,
  input wire logic miso_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    mosi_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // half an sclk period, 32 ns
  task automatic half();
    repeat (8) @(posedge clk_in);
  endtask
  // read answers come back one frame late; sclk stands high between frames
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    half();
    for (int i = 15; i >= 0; i--) begin
      sclk_out <= 1'b0;
      mosi_out <= tx[i];
      half();
      sclk_out <= 1'b1;
      rx[i] = miso_in;
      half();
    end
    half();
    cs_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
    half();
  endtask
  // only the host decides when the period becomes persistent
  task automatic flash_update();
    logic [15:0] d;
    xfer({1'b1, OFS_COMMAND, 8'h08}, d);
  endtask
endmodule

// ===== tb_aspc_top.sv
// testbench: register, timer and alarm scenarios for the alarm block
module tb_aspc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import aspc_pkg::*;
  localparam int SHORT = 8;
  localparam int LONG = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pon_n = 1'b0;
  logic cs_n, sclk, mosi, miso, miso_oe_n, upd, a1, a2, l1_out, l1_oe_n, l2_out, l2_oe_n;
  aspc_samples_t samples = '0;
  logic [15:0] lvl1 = 16'h0000;
  logic [7:0] cnt1 = 8'h01;
  logic [6:0] offs [4] = '{OFS_ALM2_LEVEL, OFS_ALM2_COUNT, OFS_ALARM_CONTROL, OFS_SMPL_PER};
  int fails = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  aspc_top #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut_u (
    .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .POWER_ON_N_IN(pon_n),
    .SPI_CS_N_IN(cs_n), .SPI_SCLK_IN(sclk), .SPI_MOSI_IN(mosi),
    .SPI_MISO_OUT(miso), .SPI_MISO_OE_N_OUT(miso_oe_n),
    .SAMPLES_IN(samples), .ALARM_ONE_LEVEL_IN(lvl1), .ALARM_ONE_COUNT_IN(cnt1),
    .GROUP_UPDATE_OUT(upd), .ALARM_ONE_ACTIVE_OUT(a1), .ALARM_TWO_ACTIVE_OUT(a2),
    .DIGITAL_LINE_FIRST_IN(l1_oe_n ? ~l1_out : l1_out),
    .DIGITAL_LINE_FIRST_OUT(l1_out), .DIGITAL_LINE_FIRST_OE_N_OUT(l1_oe_n),
    .DIGITAL_LINE_SECOND_IN(l2_oe_n ? ~l2_out : l2_out),
    .DIGITAL_LINE_SECOND_OUT(l2_out), .DIGITAL_LINE_SECOND_OE_N_OUT(l2_oe_n));
  // a released data line reads as garbage, so late enables show up as bad bits
  aspc_host_model host_u (.clk_in(clk), .cs_n_out(cs_n), .sclk_out(sclk),
    .mosi_out(mosi), .miso_in(miso_oe_n ? ~miso : miso));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [15:0] d;
    host_u.xfer({1'b1, a, v}, d);
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a | 7'h01, v[15:8]);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    logic [15:0] d;
    host_u.xfer({1'b0, a, 8'h00}, d);
    host_u.xfer(16'h0000, v);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded: a dead timer ends the run instead of hanging it
  task automatic wait_upd(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (upd !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic set_smp(input aspc_samples_t v);
    @(posedge clk);
    samples <= v;
  endtask
  task automatic do_reset(input logic pon);
    @(posedge clk);
    rst_n <= 1'b0;
    pon_n <= ~pon;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    pon_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [15:0] v;
    logic [15:0] rst_v [4];
    logic [15:0] msk [4];
    rst_v = '{RST_ALM2_LEVEL, RST_ALM2_COUNT, RST_ALARM_CONTROL, RST_SMPL_PER};
    msk = '{MASK_LEVEL, MASK_COUNT, MASK_CTRL, MASK_PER};
    for (int i = 0; i < 4; i++) begin
      rd(offs[i], v);
      chk(v, rst_v[i]);
      wr16(offs[i], 16'hFFFF);
      rd(offs[i], v);
      chk(v, msk[i]);
    end
    wr16(7'h10, 16'h1234);
    rd(7'h10, v);
    chk(v, 16'h0000);
    wr16(OFS_ALARM_CONTROL, 16'h0000);
  endtask
  task automatic t_period();
    logic [7:0] pv [4];
    int n;
    pv = '{8'h00, 8'h05, 8'h80, 8'h83};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SMPL_PER, pv[i]);
      wait_upd(n);
      wait_upd(n);
      chk(16'(n), 16'((pv[i][7] ? LONG : SHORT) * (pv[i][6:0] + 1)));
    end
  endtask
  task automatic t_flash();
    logic [15:0] v;
    int n;
    wr(OFS_SMPL_PER, 8'h01);
    wr(OFS_ALM2_COUNT, 8'h33);
    do_reset(1'b0);
    rd(OFS_SMPL_PER, v);
    chk(v, RST_SMPL_PER);
    rd(OFS_ALM2_COUNT, v);
    chk(v, 16'h0033);
    wr(OFS_SMPL_PER, 8'h01);
    host_u.flash_update();
    do_reset(1'b0);
    rd(OFS_SMPL_PER, v);
    chk(v, 16'h0001);
    wait_upd(n);
    wait_upd(n);
    chk(16'(n), 16'(SHORT * 2));
    do_reset(1'b1);
    rd(OFS_SMPL_PER, v);
    chk(v, RST_SMPL_PER);
  endtask
  task automatic t_thr();
    aspc_samples_t sv;
    wr16(OFS_ALM2_LEVEL, 16'h8100);
    wr(OFS_ALARM_CONTROL, 8'h06);
    for (int s = 1; s < 8; s++) begin
      sv = {7{14'h0200}};
      sv[s - 1] = 14'h0000;
      set_smp(sv);
      wr(OFS_ALARM_CONTROL | 7'h01, 8'(s << 4));
      tick(4);
      chk(a2, 1'b0);
      sv[s - 1] = 14'h0200;
      set_smp(sv);
      tick(4);
      chk(a2, 1'b1);
      chk({l1_oe_n, l1_out}, 2'b01);
    end
    wr16(OFS_ALM2_LEVEL, 16'h0100);
    tick(4);
    chk(a2, 1'b0);
    set_smp('0);
    tick(4);
    chk(a2, 1'b1);
    wr(OFS_ALARM_CONTROL, 8'h05);
    tick(2);
    chk({l1_oe_n, l2_oe_n, l2_out}, 3'b100);
    @(posedge clk);
    lvl1 <= 16'h8100;
    wr(OFS_ALARM_CONTROL | 7'h01, 8'h02);
    tick(4);
    chk({a2, l2_out}, 2'b01);
    set_smp({7{14'h0200}});
    tick(4);
    chk({a1, l2_out}, 2'b10);
    wr(OFS_ALARM_CONTROL, 8'h00);
    tick(2);
    chk({l1_oe_n, l2_oe_n}, 2'b11);
  endtask
  // both alarms in rate mode: a rising value trips them, a steady high value lets them go quiet
  task automatic t_roc();
    aspc_samples_t sv;
    int n;
    sv = '0;
    set_smp(sv);
    lvl1 <= 16'h8010;
    wr(OFS_SMPL_PER, 8'h00);
    wr(OFS_ALM2_COUNT, 8'h02);
    wr16(OFS_ALM2_LEVEL, 16'h8010);
    wr(OFS_ALARM_CONTROL | 7'h01, 8'hAA);
    for (int k = 0; k < 16; k++) begin
      wait_upd(n);
      if (k == 7)
        chk({a1, a2}, 2'b11);
      if (k < 8)
        sv[1] = sv[1] + 14'h0040;
      set_smp(sv);
    end
    tick(2);
    chk({a1, a2}, 2'b00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    pon_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_period();
    t_flash();
    t_thr();
    t_roc();
    stop_test();
  end
endmodule

bind aspc_top aspc_top_sva #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) chk_u (
  .CORE_CLK_IN(CORE_CLK_IN), .RESET_N_IN(RESET_N_IN), .SPI_CS_N_IN(SPI_CS_N_IN),
  .SPI_MISO_OE_N_OUT(SPI_MISO_OE_N_OUT), .GROUP_UPDATE_OUT(GROUP_UPDATE_OUT),
  .ALARM_ONE_ACTIVE_OUT(ALARM_ONE_ACTIVE_OUT), .ALARM_TWO_ACTIVE_OUT(ALARM_TWO_ACTIVE_OUT),
  .DIGITAL_LINE_FIRST_OUT(DIGITAL_LINE_FIRST_OUT),
  .DIGITAL_LINE_FIRST_OE_N_OUT(DIGITAL_LINE_FIRST_OE_N_OUT),
  .DIGITAL_LINE_SECOND_OUT(DIGITAL_LINE_SECOND_OUT),
  .DIGITAL_LINE_SECOND_OE_N_OUT(DIGITAL_LINE_SECOND_OE_N_OUT));
